// ### ref_clock_defines.svh
// Constants for the reference clock divider
// What this block does
// - Duty code 11 gives 75%, 10 gives 50%, 01 gives 25% high time
// - Divider codes 111/110/101/100 divide base clock by 128/64/32/16
// - Divider code 010 divides base clock by 4, code 001 by 2
// - Divider code 000 passes base clock, source duty, unless duty code is 0%
// - Pin carries reference clock only if fuse is 1, else system clock / 4
// - Fuse clear: block yields pin to instruction clock, system clock / 4
// - Pin output enable bit gates reference clock onto pin, else keeps it off
`ifndef REF_CLOCK_DEFINES_SVH
`define REF_CLOCK_DEFINES_SVH
`define CTRL_OFFSET 32'h0000_0000
`define STAT_OFFSET 32'h0000_0004
`define CTRL_RESET 8'h30
`define EN_BIT 7
`define OE_BIT 6
`define SLEW_BIT 5
`define DUTY_LO 3
`define DIV_LO 0
`define STAT_REF_BIT 0
`define STAT_OE_BIT 1
`define STAT_FUSE_BIT 2
`define STAT_CNT_LO 8
`define FOSC4_HALF 2'h2
`define BASE_PERIOD 9'h002
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### ref_clock_pkg.sv
// Types shared by the reference clock divider
`default_nettype none
package ref_clock_pkg;
	typedef enum logic [1:0] {
		WR_IDLE = 2'h0,
		WR_HAVE_ADDR = 2'h1,
		WR_RESP = 2'h3,
		WR_HAVE_DATA = 2'h2
	} wr_state_t;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] cnt;
		logic ref_lvl;
		logic [1:0] fosc4_cnt;
		logic fuse_s1;
		logic fuse_s2;
		logic pin_out;
		logic pin_oe;
		wr_state_t wst;
		logic aw_ctrl;
		logic aw_stat;
		logic [7:0] wdata;
		logic wstrb0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} state_t;
endpackage : ref_clock_pkg
`default_nettype wire

// ### reference_clock_divider.sv
// Reference clock divider with AXI4-Lite control register
`include "ref_clock_defines.svh"
`default_nettype none
module reference_clock_divider
	import ref_clock_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic I_REF_CLK,
	input wire logic I_SRST,
	input wire logic I_CE,
	input wire logic I_CLOCK_OUT_CONFIG_FUSE,
	output logic O_REF_CLOCK_OUT_PIN,
	output logic O_REF_CLOCK_OUT_PIN_OE,
	output logic O_SLEW_LIMIT_EN,
	input wire logic [ADDR_W-1:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [ADDR_W-1:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY
);

	generate
		if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr
			$error("ADDR_W must lie between 3 and 32");
		end
	endgenerate

	state_t st_reg;
	state_t st_next;

	// One base clock period spans two system cycles, since a flop output
	// cannot toggle faster than that; divisors count base periods.
	function automatic logic [8:0] period_of(input logic [2:0] div);
		period_of = `BASE_PERIOD << div;
	endfunction : period_of

	function automatic logic [8:0] high_of(input logic [7:0] c);
		logic [8:0] p;
		logic [8:0] h;
		p = period_of(c[`DIV_LO +: 3]);
		// Duty field selection
		// duty shaping
		case (c[`DUTY_LO +: 2])
			2'h1: h = p >> 2;
			2'h2: h = p >> 1;
			2'h3: h = p - (p >> 2);
			default: h = 9'h000;
		endcase
		if (c[`DIV_LO +: 3] == 3'h0 && c[`DUTY_LO +: 2] != 2'h0) begin
			h = 9'h001;
		end
		high_of = h;
	endfunction : high_of

	logic aw_fire;
	logic w_fire;
	logic do_wr;
	logic wr_ctrl_hit;
	logic wr_stat_hit;
	logic [7:0] wr_data;
	logic wr_strb0;
	logic ctrl_written;
	logic [8:0] period;
	logic [31:0] rd_word;

	always_comb begin
		st_next = st_reg;
		aw_fire = I_AWVALID && st_reg.awready;
		w_fire = I_WVALID && st_reg.wready;
		do_wr = 1'b0;
		wr_ctrl_hit = 1'b0;
		wr_stat_hit = 1'b0;
		wr_data = st_reg.wdata;
		wr_strb0 = st_reg.wstrb0;
		ctrl_written = 1'b0;
		rd_word = 32'h0000_0000;

		// Fuse is a pin level: two flops before use
		st_next.fuse_s1 = I_CLOCK_OUT_CONFIG_FUSE;
		st_next.fuse_s2 = st_reg.fuse_s1;

		// Write channel: address and data may come in either order
		case (st_reg.wst)
			WR_IDLE: begin
				if (aw_fire && w_fire) begin
					do_wr = 1'b1;
					wr_ctrl_hit = I_AWADDR == ADDR_W'(`CTRL_OFFSET);
					wr_stat_hit = I_AWADDR == ADDR_W'(`STAT_OFFSET);
					wr_data = I_WDATA[7:0];
					wr_strb0 = I_WSTRB[0];
				end else if (aw_fire) begin
					st_next.aw_ctrl = I_AWADDR == ADDR_W'(`CTRL_OFFSET);
					st_next.aw_stat = I_AWADDR == ADDR_W'(`STAT_OFFSET);
					st_next.wst = WR_HAVE_ADDR;
				end else if (w_fire) begin
					st_next.wdata = I_WDATA[7:0];
					st_next.wstrb0 = I_WSTRB[0];
					st_next.wst = WR_HAVE_DATA;
				end
			end
			WR_HAVE_ADDR: begin
				if (w_fire) begin
					do_wr = 1'b1;
					wr_ctrl_hit = st_reg.aw_ctrl;
					wr_stat_hit = st_reg.aw_stat;
					wr_data = I_WDATA[7:0];
					wr_strb0 = I_WSTRB[0];
				end
			end
			WR_HAVE_DATA: begin
				if (aw_fire) begin
					do_wr = 1'b1;
					wr_ctrl_hit = I_AWADDR == ADDR_W'(`CTRL_OFFSET);
					wr_stat_hit = I_AWADDR == ADDR_W'(`STAT_OFFSET);
				end
			end
			WR_RESP: begin
				if (I_BREADY) begin
					st_next.wst = WR_IDLE;
				end
			end
			default: begin
				st_next.wst = WR_IDLE;
			end
		endcase

		if (do_wr) begin
			st_next.wst = WR_RESP;
			st_next.bresp = (wr_ctrl_hit || wr_stat_hit) ? `RESP_OKAY : `RESP_SLVERR;
			// Status word is read only; a write to it is accepted and dropped
			if (wr_ctrl_hit && wr_strb0) begin
				st_next.ctrl = wr_data;
				ctrl_written = 1'b1;
			end
		end
		st_next.awready = st_next.wst == WR_IDLE || st_next.wst == WR_HAVE_DATA;
		st_next.wready = st_next.wst == WR_IDLE || st_next.wst == WR_HAVE_ADDR;
		st_next.bvalid = st_next.wst == WR_RESP;

		// Divider counter
		period = period_of(st_next.ctrl[`DIV_LO +: 3]);
		if (!st_next.ctrl[`EN_BIT] || ctrl_written) begin
			// Restart on any control write with byte 0 strobe set so a new setting never runs a stale phase
			st_next.cnt = 8'h00;
		end else if ({1'b0, st_reg.cnt} == period - 9'h001) begin
			st_next.cnt = 8'h00;
		end else begin
			st_next.cnt = st_reg.cnt + 8'h01;
		end
		st_next.ref_lvl = st_next.ctrl[`EN_BIT] && ({1'b0, st_next.cnt} < high_of(st_next.ctrl));

		// Instruction clock runs whatever the control register says
		st_next.fosc4_cnt = st_reg.fosc4_cnt + 2'h1;

		// Pin ownership
		if (st_next.fuse_s2) begin
			st_next.pin_oe = st_next.ctrl[`OE_BIT];
			st_next.pin_out = st_next.ctrl[`OE_BIT] && st_next.ref_lvl;
		end else begin
			st_next.pin_oe = 1'b1;
			st_next.pin_out = st_next.fosc4_cnt < `FOSC4_HALF;
		end

		// Read channel
		if (st_reg.rvalid && I_RREADY) begin
			st_next.rvalid = 1'b0;
		end
		if (I_ARVALID && st_reg.arready) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = `RESP_OKAY;
			if (I_ARADDR == ADDR_W'(`CTRL_OFFSET)) begin
				rd_word[7:0] = st_reg.ctrl;
			end else if (I_ARADDR == ADDR_W'(`STAT_OFFSET)) begin
				rd_word[`STAT_REF_BIT] = st_reg.ref_lvl;
				rd_word[`STAT_OE_BIT] = st_reg.pin_oe;
				rd_word[`STAT_FUSE_BIT] = st_reg.fuse_s2;
				rd_word[`STAT_CNT_LO +: 8] = st_reg.cnt;
			end else begin
				st_next.rresp = `RESP_SLVERR;
			end
			st_next.rdata = rd_word;
		end
		st_next.arready = !st_next.rvalid;
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_SRST) begin
			st_reg <= '{
				ctrl: `CTRL_RESET,
				wst: WR_IDLE,
				awready: 1'b1,
				wready: 1'b1,
				arready: 1'b1,
				default: '0
			};
		end else if (I_CE) begin
			st_reg <= st_next;
		end
	end

	assign O_REF_CLOCK_OUT_PIN = st_reg.pin_out;
	assign O_REF_CLOCK_OUT_PIN_OE = st_reg.pin_oe;
	assign O_SLEW_LIMIT_EN = st_reg.ctrl[`SLEW_BIT];
	assign O_AWREADY = st_reg.awready;
	assign O_WREADY = st_reg.wready;
	assign O_BVALID = st_reg.bvalid;
	assign O_BRESP = st_reg.bresp;
	assign O_ARREADY = st_reg.arready;
	assign O_RVALID = st_reg.rvalid;
	assign O_RRESP = st_reg.rresp;
	assign O_RDATA = st_reg.rdata;

	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (I_SRST || !I_CE);

	logic en;
	logic [1:0] duty;
	logic [2:0] div;
	assign en = st_reg.ctrl[`EN_BIT];
	assign duty = st_reg.ctrl[`DUTY_LO +: 2];
	assign div = st_reg.ctrl[`DIV_LO +: 3];

	property p_duty75;
		en && duty == 2'h3 && div == 3'h2 |-> st_reg.ref_lvl == (st_reg.cnt < 8'h06);
	endproperty
	a_duty75: assert property (p_duty75) else $error("75 percent high time wrong");

	property p_duty25;
		en && duty == 2'h1 && div == 3'h3 |-> st_reg.ref_lvl == (st_reg.cnt < 8'h04);
	endproperty
	a_duty25: assert property (p_duty25) else $error("25 percent high time wrong");

	property p_div128;
		en && div == 3'h7 && st_reg.cnt == 8'hff && st_reg.wst != WR_RESP |=> st_reg.cnt == 8'h00;
	endproperty
	a_div128: assert property (p_div128) else $error("Divide by 128 wrap wrong");

	property p_div4;
		en && div == 3'h2 && st_reg.cnt == 8'h07 && !do_wr |=> st_reg.cnt == 8'h00;
	endproperty
	a_div4: assert property (p_div4) else $error("Divide by 4 wrap wrong");

	property p_pass;
		en && div == 3'h0 && duty != 2'h0 && !do_wr |=> st_reg.ref_lvl != $past(st_reg.ref_lvl);
	endproperty
	a_pass: assert property (p_pass) else $error("Undivided clock does not toggle");

	// Two live cycles apart the pin must differ: period four, half high
	property p_fosc4;
		!st_reg.fuse_s2 && !$past(st_reg.fuse_s2) && !$past(st_reg.fuse_s2, 2) &&
			$past(I_CE) && $past(I_CE, 2) && !$past(I_SRST) && !$past(I_SRST, 2) && !$past(I_SRST, 3) |->
			O_REF_CLOCK_OUT_PIN != $past(O_REF_CLOCK_OUT_PIN, 2);
	endproperty
	a_fosc4: assert property (p_fosc4) else $error("Pin is not system clock over four");

	property p_yield;
		!st_reg.fuse_s2 && !$past(I_SRST) && $past(I_CE) |-> O_REF_CLOCK_OUT_PIN_OE;
	endproperty
	a_yield: assert property (p_yield) else $error("Pin not handed to instruction clock");

	property p_gate;
		st_reg.fuse_s2 && !st_reg.ctrl[`OE_BIT] |-> !O_REF_CLOCK_OUT_PIN_OE && !O_REF_CLOCK_OUT_PIN;
	endproperty
	a_gate: assert property (p_gate) else $error("Clock reaches pin with output disabled");

	property p_off;
		(!en || duty == 2'h0) |-> !st_reg.ref_lvl;
	endproperty
	a_off: assert property (p_off) else $error("Output high while off or 0 percent");

	property p_duty50;
		en && duty == 2'h2 && div == 3'h1 |-> st_reg.ref_lvl == (st_reg.cnt < 8'h02);
	endproperty
	a_duty50: assert property (p_duty50) else $error("50 percent high time wrong");

	property p_div16;
		en && div == 3'h4 && st_reg.cnt == 8'h1f && !do_wr |=> st_reg.cnt == 8'h00;
	endproperty
	a_div16: assert property (p_div16) else $error("Divide by 16 wrap wrong");

	property p_div2;
		en && div == 3'h1 && st_reg.cnt == 8'h03 && !do_wr |=> st_reg.cnt == 8'h00;
	endproperty
	a_div2: assert property (p_div2) else $error("Divide by 2 wrap wrong");

	property p_gate_on;
		st_reg.fuse_s2 && st_reg.ctrl[`OE_BIT] |-> O_REF_CLOCK_OUT_PIN_OE && O_REF_CLOCK_OUT_PIN == st_reg.ref_lvl;
	endproperty
	a_gate_on: assert property (p_gate_on) else $error("Reference clock missing from enabled pin");

endmodule : reference_clock_divider
`default_nettype wire

// ### ref_clock_receiver.sv
// Far-side receiver that counts pin highs and rising edges
`default_nettype none
module ref_clock_receiver (
	input wire logic i_clk,
	input wire logic i_pin,
	input wire logic i_oe,
	input wire logic i_measure,
	output logic [15:0] o_highs,
	output logic [15:0] o_rises
);
	logic lvl;
	logic last_reg;
	// Board pull-down: an undriven pin reads low, never the last value
	assign lvl = i_oe & i_pin;
	always_ff @(posedge i_clk) begin
		last_reg <= lvl;
		if (!i_measure) begin
			o_highs <= 16'h0000;
			o_rises <= 16'h0000;
		end else begin
			o_highs <= o_highs + 16'(lvl);
			o_rises <= o_rises + 16'(lvl & ~last_reg);
		end
	end
endmodule : ref_clock_receiver
`default_nettype wire

// ### test_reference_clock_divider.sv
// Self-checking testbench for the reference clock divider
`default_nettype none
module test_reference_clock_divider;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, srst = 1'b1, fuse = 1'b0, meas = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0000_0000;
	logic pin, oe, slew, awr, wr, bv, arr, rv;
	logic [1:0] br, rr, resp;
	logic [31:0] rd, data;
	logic [15:0] highs, rises;
	int num_errors = 0, compares = 0, p, h;
	initial forever #5 clk = ~clk;
	reference_clock_divider u_dut (.I_REF_CLK(clk), .I_SRST(srst), .I_CE(1'b1),
		.I_CLOCK_OUT_CONFIG_FUSE(fuse), .O_REF_CLOCK_OUT_PIN(pin), .O_REF_CLOCK_OUT_PIN_OE(oe),
		.O_SLEW_LIMIT_EN(slew), .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd),
		.I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wr), .O_BRESP(br), .O_BVALID(bv), .I_BREADY(1'b1),
		.I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rd), .O_RRESP(rr),
		.O_RVALID(rv), .I_RREADY(1'b1));
	ref_clock_receiver u_rx (.i_clk(clk), .i_pin(pin), .i_oe(oe), .i_measure(meas),
		.o_highs(highs), .o_rises(rises));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask : chk
	// Ready lines are read as they stood before the edge, so a take is seen exactly once
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (bv !== 1'b1);
		resp = br;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a);
		ara <= a;
		arv <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		resp = rr;
		data = rd;
	endtask : rd_reg
	task automatic measure(input int cycles, input int eh, input int er);
		meas <= 1'b1;
		repeat (cycles) @(posedge clk);
		meas <= 1'b0;
		#1;
		chk(32'(highs), 32'(eh), "high cycles");
		chk(32'(rises), 32'(er), "rising edges");
		@(posedge clk);
	endtask : measure
	task automatic tally_and_finish;
		$display("Counts: %0d compares, %0d num_errors", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#400us;
		num_errors++;
		tally_and_finish;
	end
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd_reg(8'h00);
		chk(data, 32'h0000_0030, "ctrl reset");
		chk(32'(slew), 32'h0000_0001, "slew reset");
		repeat (4) @(posedge clk);
		chk(32'(oe), 32'h0000_0001, "fuse clear owns pin");
		measure(16, 8, 4);
		fuse <= 1'b1;
		repeat (4) @(posedge clk);
		chk(32'(oe), 32'h0000_0000, "pin off after reset");
		// Every divider and duty code; expected counts over four output periods
		for (int d = 0; d < 8; d++) begin
			for (int c = 0; c < 4; c++) begin
				p = 2 << d;
				h = (d == 0 && c != 0) ? 1 : p * c / 4;
				wr_reg(8'h00, 32'h0000_00C0 + 32'(c * 8 + d));
				chk(32'(resp), 32'h0000_0000, "write okay");
				repeat (2 * p) @(posedge clk);
				measure(4 * p, 4 * h, (h != 0) ? 4 : 0);
			end
		end
		wr_reg(8'h00, 32'h0000_0053);
		repeat (16) @(posedge clk);
		chk(32'(oe), 32'h0000_0001, "pin enabled");
		measure(64, 0, 0);
		rd_reg(8'h04);
		chk(data, 32'h0000_0006, "status while disabled");
		wr_reg(8'h00, 32'h0000_0092);
		repeat (4) @(posedge clk);
		chk(32'(oe), 32'h0000_0000, "pin gated off");
		wr_reg(8'h04, 32'h0000_00FF);
		chk(32'(resp), 32'h0000_0000, "status write okay");
		rd_reg(8'h00);
		chk(data, 32'h0000_0092, "ctrl readback");
		wr_reg(8'h08, 32'h0000_00FF);
		chk(32'(resp), 32'h0000_0002, "unmapped write");
		rd_reg(8'h08);
		chk(32'(resp), 32'h0000_0002, "unmapped read");
		chk(data, 32'h0000_0000, "unmapped read data");
		fuse <= 1'b0;
		repeat (4) @(posedge clk);
		chk(32'(oe), 32'h0000_0001, "fuse clear again");
		measure(16, 8, 4);
		tally_and_finish;
	end
endmodule : test_reference_clock_divider
`default_nettype wire
